// ===== shared/ovs_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the output voltage sense block
// Assumes: 20 MHz reference clock
// Notes:   register offsets are the 16-bit command codes seen by the configuration port
`ifndef OVS_CONSTS_SVH
`define OVS_CONSTS_SVH

`define OVS_OFS_OV_LIMIT      16'h0040
`define OVS_OFS_OV_RESPONSE   16'h0041
`define OVS_OFS_FAST_ACTION   16'hFE01
`define OVS_OFS_OPEN_ACTION   16'hFE02
`define OVS_OFS_RISE_LEVEL    16'hFE2F
`define OVS_OFS_FALL_LEVEL    16'hFE30
`define OVS_OFS_DEBOUNCE      16'hFE31
`define OVS_OFS_HYSTERESIS    16'hFE50
`define OVS_OFS_STATUS        16'hFE80

`define OVS_ACT_MSB           7
`define OVS_ACT_LSB           6
`define OVS_LEVEL_MSB         6
`define OVS_DEB_MSB           1

`define OVS_RST_OV_LIMIT      16'h07FF
`define OVS_RST_ACTION        8'hC0
`define OVS_RST_RISE_LEVEL    8'h40
`define OVS_RST_FALL_LEVEL    8'h30
`define OVS_RST_DEBOUNCE      8'h00
`define OVS_RST_HYSTERESIS    8'h10

`define OVS_FLAG_ACCURATE     0
`define OVS_FLAG_FAST         1
`define OVS_FLAG_OPEN         2

`define OVS_CLK_HZ            20000000
`define OVS_CLK_NS            50
`define OVS_FAST_RATE_HZ      1500
`define OVS_BLANK_NS          10000
`define OVS_OPEN_DEB_NS       10000
`define OVS_DEB0_NS           120
`define OVS_DEB1_NS           240
`define OVS_DEB2_NS           480
`define OVS_DEB3_NS           640
`define OVS_BLANK_CYC         ((`OVS_BLANK_NS) / (`OVS_CLK_NS))
`define OVS_OPEN_DEB_CYC      (((`OVS_OPEN_DEB_NS) + (`OVS_CLK_NS) - 1) / (`OVS_CLK_NS))
`define OVS_DEB_CYC(ns)       ((((ns)) + (`OVS_CLK_NS) - 1) / (`OVS_CLK_NS))
`define OVS_FAST_CYC          ((`OVS_CLK_HZ) / (`OVS_FAST_RATE_HZ))

// ~100 mV of the 1.6 V span on an 11-bit code, 6.6 % of 2048
`define OVS_OPEN_DIFF         11'h087

`endif

// ===== shared/ovs_pkg.sv
// Purpose: types shared by the output voltage sense block
// Assumes: nothing beyond the constants header
// Notes:   one action encoding serves all three protection sources
package ovs_pkg;
	typedef enum logic [1:0]
	{
		OVS_ACT_SHUTDOWN  = 2'b00,
		OVS_ACT_PWM_OFF   = 2'b01,
		OVS_ACT_SOFTSTART = 2'b10,
		OVS_ACT_IGNORE    = 2'b11
	} ovs_action_e;

	typedef enum logic [1:0]
	{
		OVS_FST_ARMED      = 2'b00,
		OVS_FST_BLANK_FALL = 2'b01,
		OVS_FST_TRIPPED    = 2'b10,
		OVS_FST_BLANK_RISE = 2'b11
	} ovs_fast_e;

	typedef logic [10:0] ovs_sample_t;
endpackage

// ===== rtl/ovs_top.sv
// Purpose: output voltage sensing, half-cycle prefilter, accurate and fast overvoltage, open-loop guard
// Assumes: all inputs synchronous to ref_clk; adc samples arrive with one-cycle valid strobes
// Notes:   one shared serial divider turns sums into averages; half-cycle jobs take priority
//
// Overview of operation
// - Deliver an 11-bit feedback average once per half line cycle to the normal loop.
// - Deliver a 10-bit feedback average refreshed at 1.5 kHz to the fast loop.
// - Zero crossings of input voltage mark each half line cycle boundary.
// - Average every feedback sample inside one half line cycle and present it.
// - Set accurate overvoltage flag when half-cycle average exceeds the limit register.
// - Accurate overvoltage flag triggers the action chosen in the response register.
// - With PWM-off response, release accurate condition only below limit minus hysteresis.
// - Fast comparator ignores pulses shorter than 120, 240, 480 or 640 ns.
// - Rising and falling fast thresholds each come from a 7-bit field.
// - On rising trip apply fast action and switch reference to falling level if different.
// - Blank the fast comparator for 10 us whenever its reference switches.
// - Fast overvoltage releases when the sense drops below the falling threshold.
// - Two-bit fast response: shutdown, PWM off until cleared, soft start, ignore.
// - Flag open loop when redundant and feedback inputs differ by more than ~100 mV.
// - Open-loop difference must persist 10 us before the fault is recognised.
// - Two-bit open-loop response picks the same four actions.
`timescale 1ns/1ps
`include "ovs_consts.svh"

module ovs_top
#(
	parameter int unsigned FAST_CYCLES = `OVS_FAST_CYC,
	parameter int unsigned ZC_LEVEL    = 64,
	parameter int unsigned CNT_W       = 16
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	input  wire ovs_pkg::ovs_sample_t output_feedback_input,
	input  wire logic             feedback_valid,
	input  wire ovs_pkg::ovs_sample_t redundant_overvoltage_input,
	input  wire ovs_pkg::ovs_sample_t line_voltage_input,
	input  wire logic             line_valid,
	input  wire logic             fast_comparator_out,
	input  wire logic             power_on_request,
	input  wire logic [15:0]      reg_addr,
	input  wire logic [15:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [15:0]           reg_rdata,
	output ovs_pkg::ovs_sample_t  half_cycle_average,
	output logic                  half_cycle_valid,
	output logic [9:0]            fast_loop_average,
	output logic                  fast_loop_valid,
	output logic [6:0]            fast_reference_level,
	output logic                  pwm_disable,
	output logic                  shutdown_hold,
	output logic                  soft_start_req
);
	import ovs_pkg::*;

	localparam int SUM_W = 11 + CNT_W;
	localparam int BLANK_CYC = `OVS_BLANK_CYC;
	localparam int OPEN_CYC = `OVS_OPEN_DEB_CYC;

	logic [15:0]       ov_limit;
	logic [7:0]        ov_response;
	logic [7:0]        fast_action;
	logic [7:0]        open_action;
	logic [7:0]        trip_level_high;
	logic [7:0]        release_level_low;
	logic [7:0]        debounce_sel;
	logic [7:0]        hysteresis;
	logic [2:0]        flags;
	logic [2:0]        evt;
	logic              status_wr;
	logic              acc_active;
	ovs_fast_e         fst;
	logic              shutdown_latch;
	logic              pwr_q;

	function automatic logic [4:0] deb_cycles(input logic [1:0] sel);
		unique case (sel)
			2'b00: deb_cycles = 5'(`OVS_DEB_CYC(`OVS_DEB0_NS));
			2'b01: deb_cycles = 5'(`OVS_DEB_CYC(`OVS_DEB1_NS));
			2'b10: deb_cycles = 5'(`OVS_DEB_CYC(`OVS_DEB2_NS));
			2'b11: deb_cycles = 5'(`OVS_DEB_CYC(`OVS_DEB3_NS));
		endcase
	endfunction

	// configuration writes; the status word is write-one-to-clear
	assign status_wr = reg_wr && (reg_addr == `OVS_OFS_STATUS);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ov_limit          <= `OVS_RST_OV_LIMIT;
			ov_response       <= `OVS_RST_ACTION;
			fast_action       <= `OVS_RST_ACTION;
			open_action       <= `OVS_RST_ACTION;
			trip_level_high   <= `OVS_RST_RISE_LEVEL;
			release_level_low <= `OVS_RST_FALL_LEVEL;
			debounce_sel      <= `OVS_RST_DEBOUNCE;
			hysteresis        <= `OVS_RST_HYSTERESIS;
		end
		else if (clk_en && reg_wr)
		begin
			unique case (reg_addr)
				`OVS_OFS_OV_LIMIT:    ov_limit <= reg_wdata;
				`OVS_OFS_OV_RESPONSE: ov_response <= reg_wdata[7:0];
				`OVS_OFS_FAST_ACTION: fast_action <= reg_wdata[7:0];
				`OVS_OFS_OPEN_ACTION: open_action <= reg_wdata[7:0];
				`OVS_OFS_RISE_LEVEL:  trip_level_high <= {1'b0, reg_wdata[`OVS_LEVEL_MSB:0]};
				`OVS_OFS_FALL_LEVEL:  release_level_low <= {1'b0, reg_wdata[`OVS_LEVEL_MSB:0]};
				`OVS_OFS_DEBOUNCE:    debounce_sel <= {6'h00, reg_wdata[`OVS_DEB_MSB:0]};
				`OVS_OFS_HYSTERESIS:  hysteresis <= reg_wdata[7:0];
				default:              ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 16'h0000;
		else if (clk_en && reg_rd)
		begin
			unique case (reg_addr)
				`OVS_OFS_OV_LIMIT:    reg_rdata <= ov_limit;
				`OVS_OFS_OV_RESPONSE: reg_rdata <= {8'h00, ov_response};
				`OVS_OFS_FAST_ACTION: reg_rdata <= {8'h00, fast_action};
				`OVS_OFS_OPEN_ACTION: reg_rdata <= {8'h00, open_action};
				`OVS_OFS_RISE_LEVEL:  reg_rdata <= {8'h00, trip_level_high};
				`OVS_OFS_FALL_LEVEL:  reg_rdata <= {8'h00, release_level_low};
				`OVS_OFS_DEBOUNCE:    reg_rdata <= {8'h00, debounce_sel};
				`OVS_OFS_HYSTERESIS:  reg_rdata <= {8'h00, hysteresis};
				`OVS_OFS_STATUS:      reg_rdata <= {9'h000, fst, shutdown_latch, acc_active, flags};
				default:              reg_rdata <= 16'h0000;
			endcase
		end
	end

	// zero-cross detector: a falling pass through ZC_LEVEL on the rectified line
	logic zc_armed;
	logic zc_pulse;
	assign zc_pulse = line_valid && zc_armed && (line_voltage_input <= 11'(ZC_LEVEL));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			zc_armed <= 1'b0;
		else if (clk_en && line_valid)
			zc_armed <= (line_voltage_input > 11'(ZC_LEVEL));
	end

	// accumulators; a sample landing on a boundary opens the next window
	logic [SUM_W-1:0] half_sum, fast_sum, pend_half_sum, pend_fast_sum;
	logic [CNT_W-1:0] half_cnt, fast_cnt, pend_half_cnt, pend_fast_cnt;
	logic [15:0]      fast_tmr;
	logic             fast_tick, pend_half, pend_fast;
	logic [SUM_W-1:0] smp_ext;
	logic [CNT_W-1:0] smp_one;
	assign fast_tick = (fast_tmr == 16'(FAST_CYCLES - 1));
	assign smp_ext = feedback_valid ? SUM_W'(output_feedback_input) : '0;
	assign smp_one = feedback_valid ? CNT_W'(1) : '0;

	// sum samples over the half cycle and the fast window
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			half_sum <= '0;
			half_cnt <= '0;
			fast_sum <= '0;
			fast_cnt <= '0;
			fast_tmr <= 16'h0000;
		end
		else if (clk_en)
		begin
			half_sum <= zc_pulse ? smp_ext : half_sum + smp_ext;
			half_cnt <= zc_pulse ? smp_one : half_cnt + smp_one;
			fast_sum <= fast_tick ? smp_ext : fast_sum + smp_ext;
			fast_cnt <= fast_tick ? smp_one : fast_cnt + smp_one;
			fast_tmr <= fast_tick ? 16'h0000 : fast_tmr + 16'h0001;
		end
	end

	// shared restoring divider, one quotient bit per cycle
	logic [SUM_W-1:0] div_quo;
	logic [CNT_W:0]   div_rem;
	logic [CNT_W-1:0] div_den;
	logic [5:0]       div_step;
	logic             div_busy, div_job_half, div_start_half, div_start_fast;
	logic [CNT_W:0]   div_trial;
	assign div_trial = {div_rem[CNT_W-1:0], div_quo[SUM_W-1]};
	assign div_start_half = !div_busy && pend_half;
	assign div_start_fast = !div_busy && !pend_half && pend_fast;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pend_half     <= 1'b0;
			pend_fast     <= 1'b0;
			pend_half_sum <= '0;
			pend_half_cnt <= '0;
			pend_fast_sum <= '0;
			pend_fast_cnt <= '0;
		end
		else if (clk_en)
		begin
			// an empty window has no average and is dropped
			if (zc_pulse)
			begin
				pend_half     <= (half_cnt != '0);
				pend_half_sum <= half_sum;
				pend_half_cnt <= half_cnt;
			end
			else if (div_start_half)
				pend_half <= 1'b0;
			if (fast_tick)
			begin
				pend_fast     <= (fast_cnt != '0);
				pend_fast_sum <= fast_sum;
				pend_fast_cnt <= fast_cnt;
			end
			else if (div_start_fast)
				pend_fast <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_busy     <= 1'b0;
			div_job_half <= 1'b0;
			div_step     <= 6'h00;
			div_quo      <= '0;
			div_rem      <= '0;
			div_den      <= '0;
		end
		else if (clk_en)
		begin
			if (div_start_half || div_start_fast)
			begin
				div_busy     <= 1'b1;
				div_job_half <= div_start_half;
				div_step     <= 6'(SUM_W);
				div_quo      <= div_start_half ? pend_half_sum : pend_fast_sum;
				div_den      <= div_start_half ? pend_half_cnt : pend_fast_cnt;
				div_rem      <= '0;
			end
			else if (div_busy)
			begin
				// busy stays up through the step-zero cycle so the finished quotient is seen once
				if (div_step == 6'h00)
					div_busy <= 1'b0;
				else
				begin
					div_step <= div_step - 6'h01;
					if (div_trial >= {1'b0, div_den})
					begin
						div_rem <= div_trial - {1'b0, div_den};
						div_quo <= {div_quo[SUM_W-2:0], 1'b1};
					end
					else
					begin
						div_rem <= div_trial;
						div_quo <= {div_quo[SUM_W-2:0], 1'b0};
					end
				end
			end
		end
	end

	logic div_done;
	assign div_done = div_busy && (div_step == 6'h00);

	// publish averages to the two voltage loops
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			half_cycle_average <= '0;
			half_cycle_valid   <= 1'b0;
			fast_loop_average  <= 10'h000;
			fast_loop_valid    <= 1'b0;
		end
		else if (clk_en)
		begin
			half_cycle_valid <= div_done && div_job_half;
			fast_loop_valid  <= div_done && !div_job_half;
			if (div_done && div_job_half)
				half_cycle_average <= div_quo[10:0];
			if (div_done && !div_job_half)
				fast_loop_average <= div_quo[10:1];
		end
	end

	// accurate overvoltage, judged on each fresh half-cycle average
	logic [16:0] avg_w, lim_w, rel_w;
	logic        acc_trip, acc_pwm_mode;
	assign avg_w = 17'(half_cycle_average);
	assign lim_w = {1'b0, ov_limit};
	assign acc_pwm_mode = (ovs_action_e'(ov_response[`OVS_ACT_MSB:`OVS_ACT_LSB]) == OVS_ACT_PWM_OFF);
	assign rel_w = acc_pwm_mode ? lim_w - 17'(hysteresis) : lim_w;
	assign acc_trip = half_cycle_valid && (avg_w > lim_w);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			acc_active <= 1'b0;
		else if (clk_en && half_cycle_valid)
			// a hysteresis larger than the limit wraps the release point below zero: never release then
			acc_active <= (acc_active && acc_pwm_mode) ? (rel_w[16] || avg_w >= rel_w) : (avg_w > lim_w);
	end

	// fast overvoltage: debounce, threshold swap and blanking
	logic [4:0] deb_cnt;
	logic [8:0] blank_cnt;
	logic       fast_trip, fast_release, comp_target;
	assign comp_target = (fst == OVS_FST_ARMED);
	// debounce length from the two-bit field
	assign fast_trip = (fst == OVS_FST_ARMED) && fast_comparator_out && (deb_cnt + 5'h01 >= deb_cycles(debounce_sel[1:0]));
	assign fast_release = (fst == OVS_FST_TRIPPED) && !fast_comparator_out
		&& (deb_cnt + 5'h01 >= deb_cycles(debounce_sel[1:0]));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			fst                  <= OVS_FST_ARMED;
			deb_cnt              <= 5'h00;
			blank_cnt            <= 9'h000;
			fast_reference_level <= 7'h00;
		end
		else if (clk_en)
		begin
			deb_cnt <= (fast_comparator_out == comp_target || fst == OVS_FST_TRIPPED && !fast_comparator_out)
				&& !fast_trip && !fast_release && !fst[0] ? deb_cnt + 5'h01 : 5'h00;
			unique case (fst)
				OVS_FST_ARMED:
				begin
					fast_reference_level <= trip_level_high[6:0];
					// swap to falling level on trip
					if (fast_trip)
					begin
						fast_reference_level <= release_level_low[6:0];
						blank_cnt <= 9'(BLANK_CYC - 1);
						fst <= (trip_level_high != release_level_low) ? OVS_FST_BLANK_FALL : OVS_FST_TRIPPED;
					end
				end
				OVS_FST_TRIPPED:
				begin
					fast_reference_level <= release_level_low[6:0];
					if (fast_release)
					begin
						fast_reference_level <= trip_level_high[6:0];
						blank_cnt <= 9'(BLANK_CYC - 1);
						fst <= (trip_level_high != release_level_low) ? OVS_FST_BLANK_RISE : OVS_FST_ARMED;
					end
				end
				OVS_FST_BLANK_FALL, OVS_FST_BLANK_RISE:
				begin
					blank_cnt <= blank_cnt - 9'h001;
					if (blank_cnt == 9'h000)
						fst <= (fst == OVS_FST_BLANK_FALL) ? OVS_FST_TRIPPED : OVS_FST_ARMED;
				end
			endcase
		end
	end

	// open-loop guard: redundant sense versus feedback
	logic [11:0] open_diff;
	logic        open_big, open_evt;
	logic [7:0]  open_cnt;
	assign open_diff = 12'(redundant_overvoltage_input) - 12'(output_feedback_input);
	assign open_big = (open_diff[11] ? 11'(-open_diff) : open_diff[10:0]) > `OVS_OPEN_DIFF;
	assign open_evt = open_big && (open_cnt == 8'(OPEN_CYC - 1));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			open_cnt <= 8'h00;
		else if (clk_en)
			open_cnt <= !open_big ? 8'h00 : (open_evt ? open_cnt : open_cnt + 8'h01);
	end

	// sticky flags, a set in the clearing cycle wins
	assign evt[`OVS_FLAG_ACCURATE] = acc_trip;
	assign evt[`OVS_FLAG_FAST]     = fast_trip;
	assign evt[`OVS_FLAG_OPEN]     = open_evt && !flags[`OVS_FLAG_OPEN];

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			flags <= 3'b000;
		else if (clk_en)
			flags <= (flags & ~(status_wr ? reg_wdata[2:0] : 3'b000)) | evt;
	end

	// action dispatch per source
	ovs_action_e act[3];
	logic [2:0]  want_stop, want_soft, want_pwm;
	assign act[0] = ovs_action_e'(ov_response[`OVS_ACT_MSB:`OVS_ACT_LSB]);
	assign act[1] = ovs_action_e'(fast_action[`OVS_ACT_MSB:`OVS_ACT_LSB]);
	assign act[2] = ovs_action_e'(open_action[`OVS_ACT_MSB:`OVS_ACT_LSB]);

	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			want_stop[i] = evt[i] && (act[i] == OVS_ACT_SHUTDOWN);
			want_soft[i] = evt[i] && (act[i] == OVS_ACT_SOFTSTART);
			want_pwm[i]  = flags[i] && (act[i] == OVS_ACT_PWM_OFF);
		end
		// accurate pwm-off follows the hysteresis-governed condition instead
		want_pwm[0] = acc_active && acc_pwm_mode;
	end

	// shutdown holds until a fresh power-on request edge
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pwr_q          <= 1'b0;
			shutdown_latch <= 1'b0;
			shutdown_hold  <= 1'b0;
			soft_start_req <= 1'b0;
			pwm_disable    <= 1'b0;
		end
		else if (clk_en)
		begin
			pwr_q          <= power_on_request;
			shutdown_latch <= (|want_stop) || (shutdown_latch && !(power_on_request && !pwr_q));
			shutdown_hold  <= (|want_stop) || (shutdown_latch && !(power_on_request && !pwr_q));
			soft_start_req <= |want_soft;
			pwm_disable    <= (|want_stop) || shutdown_latch || (|want_pwm);
		end
	end

	sequence s_trip_swap;
		fst == OVS_FST_ARMED && fast_trip && trip_level_high != release_level_low && clk_en;
	endsequence
	sequence s_in_fall_blank;
		fst == OVS_FST_BLANK_FALL && fast_reference_level == release_level_low[6:0];
	endsequence

	a_half_avg_out: assert property (@(posedge ref_clk) disable iff (rst)
		div_done && div_job_half && clk_en |=> half_cycle_valid && half_cycle_average == $past(div_quo[10:0]))
		else $error("half-cycle average not published");
	a_fast_avg_out: assert property (@(posedge ref_clk) disable iff (rst)
		div_done && !div_job_half && clk_en |=> fast_loop_valid && fast_loop_average == $past(div_quo[10:1]))
		else $error("fast-loop average not published");
	a_acc_ov_set: assert property (@(posedge ref_clk) disable iff (rst)
		half_cycle_valid && clk_en && avg_w > lim_w |=> flags[0] && acc_active)
		else $error("accurate overvoltage not flagged");
	a_trip_swap_ref: assert property (@(posedge ref_clk) disable iff (rst)
		s_trip_swap |=> s_in_fall_blank)
		else $error("reference not moved to falling level");
	a_blank_hold: assert property (@(posedge ref_clk) disable iff (rst)
		fst[0] && blank_cnt != 9'h000 && clk_en |=> fst == $past(fst) && !fast_trip && !fast_release)
		else $error("blanking cut short");
	a_open_persist: assert property (@(posedge ref_clk) disable iff (rst)
		open_evt && clk_en |-> $past(open_big, 1) && $past(open_big, 8) && open_cnt == 8'(OPEN_CYC - 1))
		else $error("open-loop fault without persistence");
	a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && !status_wr |=> (flags & $past(flags)) == $past(flags))
		else $error("flag dropped without a clear");
	a_fast_shutdown: assert property (@(posedge ref_clk) disable iff (rst)
		fast_trip && clk_en && act[1] == OVS_ACT_SHUTDOWN |=> shutdown_hold && pwm_disable)
		else $error("fast shutdown action missing");
	a_debounce_min: assert property (@(posedge ref_clk) disable iff (rst)
		fast_trip && clk_en |-> fast_comparator_out && deb_cnt == deb_cycles(debounce_sel[1:0]) - 5'h01)
		else $error("fast trip before debounce");
endmodule

// ===== tb/ovs_rail_model.sv
// Purpose: boost output rail seen through two dividers, plus rectified line samples
// Assumes: the bench sets the rail code and any mismatch between the dividers
// Notes:   one sample every 4 cycles, 64 per half line cycle
`timescale 1ns/1ps
module ovs_rail_model
(
	input  wire logic         ref_clk,
	input  wire logic [10:0]  rail_code,
	input  wire logic [10:0]  divider_error,
	input  wire logic [6:0]   fast_reference_level,
	output logic [10:0]       output_feedback_input,
	output logic              feedback_valid,
	output logic [10:0]       redundant_overvoltage_input,
	output logic [10:0]       line_voltage_input,
	output logic              line_valid,
	output logic              fast_comparator_out
);
	logic [7:0] phase = 8'h00;
	always_ff @(posedge ref_clk)
	begin
		phase <= phase + 8'h01;
	end
	assign feedback_valid = (phase[1:0] == 2'h3);
	assign line_valid = feedback_valid;
	// ramp wraps to zero each half cycle, so every wrap is a crossing
	assign line_voltage_input = {phase[7:2], 5'h00};
	assign output_feedback_input = rail_code;
	assign redundant_overvoltage_input = rail_code + divider_error;
	// the dac code stands against the top seven bits of the redundant sense
	assign fast_comparator_out = (redundant_overvoltage_input[10:4] > fast_reference_level);
endmodule

// ===== tb/output_voltage_sense_protect_test.sv
// Purpose: register, averaging and protection checks of the sense block
// Assumes: fast window shortened to 200 cycles
// Notes:   all outputs are sampled on the falling edge
`timescale 1ns/1ps
`include "ovs_consts.svh"
module output_voltage_sense_protect_test;
	import ovs_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic power_on_request = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [10:0] rail_code = 11'h3E8;
	logic [10:0] divider_error = 11'h000;
	logic [10:0] output_feedback_input, redundant_overvoltage_input, line_voltage_input, half_cycle_average;
	logic feedback_valid, line_valid, fast_comparator_out, half_cycle_valid, fast_loop_valid;
	logic pwm_disable, shutdown_hold, soft_start_req;
	logic [15:0] reg_rdata;
	logic [15:0] rd;
	logic [9:0] fast_loop_average;
	logic [6:0] fast_reference_level;
	int mismatches = 0;
	int checked = 0;
	int n;

	ovs_top #(.FAST_CYCLES(200)) u_dut
	(
		.ref_clk, .rst, .clk_en, .output_feedback_input, .feedback_valid, .redundant_overvoltage_input,
		.line_voltage_input, .line_valid, .fast_comparator_out, .power_on_request, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .half_cycle_average, .half_cycle_valid, .fast_loop_average,
		.fast_loop_valid, .fast_reference_level, .pwm_disable, .shutdown_hold, .soft_start_req
	);
	ovs_rail_model u_rail
	(
		.ref_clk, .rail_code, .divider_error, .fast_reference_level, .output_feedback_input, .feedback_valid,
		.redundant_overvoltage_input, .line_voltage_input, .line_valid, .fast_comparator_out
	);

	initial
	begin
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic read_check(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] mask, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		rd = reg_rdata;
		check(what, exp, rd & mask);
	endtask

	// 0 half cycle, 1 fast window, 2 soft start; a limit that runs out is a mismatch
	task automatic wait_pulse(input int which, input int limit);
		@(negedge ref_clk);
		for (n = 0; n < limit && ((which == 0) ? half_cycle_valid : (which == 1) ? fast_loop_valid
			: soft_start_req) !== 1'b1; n++)
			@(negedge ref_clk);
		check("pulse wait", 16'h0000, 16'(n == limit));
	endtask

	task automatic set_rail(input logic [10:0] v, input int hold);
		@(posedge ref_clk);
		rail_code <= v;
		repeat (hold) @(negedge ref_clk);
	endtask

	task automatic give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#(20000 * 50);
		mismatches++;
		give_verdict();
	end

	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		read_check(`OVS_OFS_OV_LIMIT, 16'h07FF, 16'hFFFF, "limit");
		read_check(`OVS_OFS_FAST_ACTION, 16'h00C0, 16'hFFFF, "fast action");
		read_check(`OVS_OFS_OPEN_ACTION, 16'h00C0, 16'hFFFF, "open action");
		read_check(`OVS_OFS_FALL_LEVEL, 16'h0030, 16'hFFFF, "fall level");
		read_check(`OVS_OFS_HYSTERESIS, 16'h0010, 16'hFFFF, "hysteresis");
		read_check(16'h1234, 16'h0000, 16'hFFFF, "unmapped");
		reg_write(`OVS_OFS_RISE_LEVEL, 16'h00FF);
		read_check(`OVS_OFS_RISE_LEVEL, 16'h007F, 16'hFFFF, "rise level");
		// a write offered while the clock enable is low must not land
		@(posedge ref_clk);
		clk_en <= 1'b0;
		reg_write(`OVS_OFS_HYSTERESIS, 16'h0055);
		clk_en <= 1'b1;
		read_check(`OVS_OFS_HYSTERESIS, 16'h0010, 16'hFFFF, "frozen write");
		wait_pulse(0, 700);
		check("half average", 16'h03E8, {5'h00, half_cycle_average});
		wait_pulse(1, 400);
		check("fast average", 16'h01F4, {6'h00, fast_loop_average});
		// limit 900, pwm off; 890 sits inside the hysteresis band
		reg_write(`OVS_OFS_OV_LIMIT, 16'h0384);
		reg_write(`OVS_OFS_OV_RESPONSE, 16'h0040);
		wait_pulse(0, 700);
		wait_pulse(0, 700);
		repeat (3) @(negedge ref_clk);
		check("pwm off", 16'h0001, 16'(pwm_disable));
		set_rail(11'h37A, 1);
		wait_pulse(0, 700);
		wait_pulse(0, 700);
		repeat (3) @(negedge ref_clk);
		check("pwm held", 16'h0001, 16'(pwm_disable));
		set_rail(11'h366, 1);
		wait_pulse(0, 700);
		wait_pulse(0, 700);
		repeat (3) @(negedge ref_clk);
		check("pwm released", 16'h0000, 16'(pwm_disable));
		read_check(`OVS_OFS_STATUS, 16'h0001, 16'hFFFF, "status held");
		reg_write(`OVS_OFS_STATUS, 16'h0007);
		read_check(`OVS_OFS_STATUS, 16'h0000, 16'h0007, "status cleared");
		reg_write(`OVS_OFS_OV_RESPONSE, 16'h00C0);
		reg_write(`OVS_OFS_FAST_ACTION, 16'h0000);
		reg_write(`OVS_OFS_RISE_LEVEL, 16'h0050);
		reg_write(`OVS_OFS_FALL_LEVEL, 16'h0048);
		reg_write(`OVS_OFS_DEBOUNCE, 16'h00FF);
		read_check(`OVS_OFS_DEBOUNCE, 16'h0003, 16'hFFFF, "debounce");
		// twelve cycles (600 ns) above the trip level stay under the 640 ns debounce
		set_rail(11'h578, 12);
		set_rail(11'h366, 10);
		check("glitch ignored", 16'h0000, 16'(shutdown_hold));
		check("rise ref", 16'h0050, 16'(fast_reference_level));
		set_rail(11'h578, 20);
		check("shutdown", 16'h0003, {14'h0000, shutdown_hold, pwm_disable});
		check("fall ref", 16'h0048, 16'(fast_reference_level));
		set_rail(11'h366, 100);
		check("blanked ref", 16'h0048, 16'(fast_reference_level));
		repeat (200) @(negedge ref_clk);
		check("released ref", 16'h0050, 16'(fast_reference_level));
		read_check(`OVS_OFS_STATUS, 16'h0002, 16'h0002, "fast flag");
		check("still shut", 16'h0001, 16'(shutdown_hold));
		@(posedge ref_clk);
		power_on_request <= 1'b1;
		repeat (4) @(negedge ref_clk);
		check("power on", 16'h0000, 16'(shutdown_hold));
		reg_write(`OVS_OFS_OPEN_ACTION, 16'h0080);
		@(posedge ref_clk);
		divider_error <= 11'h0C8;
		wait_pulse(2, 400);
		check("open debounce", 16'h0001, 16'(n >= 195));
		set_rail(11'h000, 4); // far side soft-starts the supply from zero on the fault
		give_verdict();
	end
endmodule
